/* File: pscm_top.sv */
`timescale 1ns/10ps
`default_nettype none

module pscm_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor core
  input wire logic psave_req,
  input wire logic psave_sleep,
  input wire logic irq_pending,
  input wire logic osc_unlocked,
  // watchdog and monitor
  input wire logic wdt_enabled,
  input wire logic mon_enabled,
  input wire logic wdt_timeout,
  // clock controls
  output logic cpu_clk_en,
  output logic [15:0] periph_clk_en_one,
  output logic [15:0] periph_clk_en_two,
  output logic sysclk_run,
  output logic [2:0] active_osc,
  output logic rc_clk_run,
  output logic mon_active,
  output logic wdt_clear,
  output logic cpu_halted,
  output logic wake_pulse
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // terminal count of the cpu divider for a ratio code
  function automatic logic [6:0] dz_mask(input logic [2:0] code);
    dz_mask = 7'((8'h01 << code) - 8'h01);
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  pscm_pkg::pscm_state_t state_ff, nxt_state;
  logic [2:0] newsel_ff;
  logic rtn_ff, nxt_rtn;
  logic doze_en_ff, nxt_doze_en;
  logic [2:0] ratio_ff, nxt_ratio;
  logic [15:0] pd1_ff, pd2_ff;
  logic [6:0] dz_cnt_ff, nxt_dz_cnt;
  logic wto_s1_ff, wto_s2_ff, wto_s3_ff, wto_lvl_ff;
  logic cpu_clk_en_ff, sysclk_run_ff, rc_clk_run_ff, mon_active_ff;
  logic wdt_clear_ff, cpu_halted_ff, wake_pulse_ff;
  logic [2:0] active_osc_ff;
  logic [15:0] pce1_ff, pce2_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire setup = psel & ~penable;
  wire hit_osc = (paddr == pscm_pkg::ADDR_OSC);
  wire hit_cdv = (paddr == pscm_pkg::ADDR_CDV);
  wire hit_pd1 = (paddr == pscm_pkg::ADDR_PD1);
  wire hit_pd2 = (paddr == pscm_pkg::ADDR_PD2);
  wire hit_sta = (paddr == pscm_pkg::ADDR_STA);
  wire mapped = hit_osc | hit_cdv | hit_pd1 | hit_pd2 | hit_sta;
  wire wr_ok = psel & penable & pready_ff & pwrite & ~pslverr_ff;
  wire wr_osc = wr_ok & hit_osc & osc_unlocked;
  wire wr_cdv = wr_ok & hit_cdv;
  wire wr_pd1 = wr_ok & hit_pd1;
  wire wr_pd2 = wr_ok & hit_pd2;

  // ----------------------------------------
  // power state machine
  // ----------------------------------------
  wire wdt_to = wto_lvl_ff;
  wire wake = irq_pending | wdt_to;
  wire halted = (state_ff == pscm_pkg::PS_SLEEP) | (state_ff == pscm_pkg::PS_IDLE);
  wire in_sleep = (state_ff == pscm_pkg::PS_SLEEP);
  wire in_run = (state_ff == pscm_pkg::PS_RUN);

  // entry takes one cycle in which wake sources are not looked at, so an
  // interrupt racing the request is served only once the state is reached
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pscm_pkg::PS_RUN: begin
        if (psave_req) begin
          nxt_state = pscm_pkg::PS_ENTER;
        end
      end
      pscm_pkg::PS_ENTER: begin
        nxt_state = psave_sleep ? pscm_pkg::PS_SLEEP : pscm_pkg::PS_IDLE;
      end
      pscm_pkg::PS_SLEEP, pscm_pkg::PS_IDLE: begin
        if (wake) begin
          nxt_state = pscm_pkg::PS_RUN;
        end
      end
      default: begin
        nxt_state = pscm_pkg::PS_RUN;
      end
    endcase
  end

  // ----------------------------------------
  // doze divider
  // ----------------------------------------
  wire doze_on = doze_en_ff & in_run;
  wire dz_tick = (dz_cnt_ff == dz_mask(ratio_ff));
  wire rtn_hit = in_run & irq_pending & rtn_ff;

  // divider restarts whenever doze is off so the first slow tick is clean
  assign nxt_dz_cnt = (~doze_on | dz_tick) ? 7'h00 : 7'(dz_cnt_ff + 7'h01);

  // hardware clear of doze beats a same-cycle software write
  assign nxt_doze_en = rtn_hit ? 1'b0 :
                       wr_cdv ? pwdata[pscm_pkg::CDV_DOZE_BIT] : doze_en_ff;
  assign nxt_rtn = wr_cdv ? pwdata[pscm_pkg::CDV_RTN_BIT] : rtn_ff;
  assign nxt_ratio = wr_cdv ? pwdata[pscm_pkg::CDV_RATIO_LSB +: 3] : ratio_ff;

  // read word mux, placed after the state decode it reports; unimplemented bits read zero
  wire [31:0] rd_osc = {21'h00_0000, newsel_ff, 8'h00};
  wire [31:0] rd_cdv = {16'h0000, rtn_ff, ratio_ff, doze_en_ff, 11'h000};
  wire [31:0] rd_pd1 = {16'h0000, pd1_ff};
  wire [31:0] rd_pd2 = {16'h0000, pd2_ff};
  wire [31:0] rd_sta = {29'h0000_0000, doze_on, state_ff};
  wire [31:0] rd_word = hit_osc ? rd_osc :
                        hit_cdv ? rd_cdv :
                        hit_pd1 ? rd_pd1 :
                        hit_pd2 ? rd_pd2 :
                        hit_sta ? rd_sta : 32'h0000_0000;

  // ----------------------------------------
  // apb slave: one wait-free access phase
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~mapped;
      prdata_ff <= (setup & ~pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      newsel_ff <= pscm_pkg::NEWSEL_RST;
      rtn_ff <= 1'b0;
      doze_en_ff <= 1'b0;
      ratio_ff <= pscm_pkg::RATIO_RST;
      pd1_ff <= pscm_pkg::PD_RST;
      pd2_ff <= pscm_pkg::PD_RST;
    end else begin
      if (wr_osc) begin
        newsel_ff <= pwdata[pscm_pkg::OSC_NEWSEL_LSB +: 3];
      end
      rtn_ff <= nxt_rtn;
      doze_en_ff <= nxt_doze_en;
      ratio_ff <= nxt_ratio;
      if (wr_pd1) begin
        pd1_ff <= pwdata[15:0] & pscm_pkg::PD1_MASK;
      end
      if (wr_pd2) begin
        pd2_ff <= pwdata[15:0] & pscm_pkg::PD2_MASK;
      end
    end
  end

  // ----------------------------------------
  // watchdog time-out synchroniser
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wto_s1_ff <= 1'b0;
      wto_s2_ff <= 1'b0;
      wto_s3_ff <= 1'b0;
      wto_lvl_ff <= 1'b0;
    end else begin
      wto_s1_ff <= wdt_timeout;
      wto_s2_ff <= wto_s1_ff;
      wto_s3_ff <= wto_s2_ff;
      // a level change counts only once stages two and three agree, so a glitch sampled for a single cycle never wakes
      if (wto_s2_ff == wto_s3_ff) begin
        wto_lvl_ff <= wto_s3_ff;
      end
    end
  end

  // ----------------------------------------
  // state and divider
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= pscm_pkg::PS_RUN;
      dz_cnt_ff <= 7'h00;
    end else begin
      state_ff <= nxt_state;
      dz_cnt_ff <= nxt_dz_cnt;
    end
  end

  // ----------------------------------------
  // registered clock enables and status
  // ----------------------------------------
  // all enables are flops on pclk, so a gate opens or shuts only at an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en_ff <= 1'b0;
      sysclk_run_ff <= 1'b1;
      active_osc_ff <= pscm_pkg::NEWSEL_RST;
      rc_clk_run_ff <= 1'b0;
      mon_active_ff <= 1'b0;
      wdt_clear_ff <= 1'b0;
      cpu_halted_ff <= 1'b0;
      wake_pulse_ff <= 1'b0;
      pce1_ff <= 16'h0000;
      pce2_ff <= 16'h0000;
    end else begin
      cpu_clk_en_ff <= in_run & (~doze_en_ff | dz_tick);
      sysclk_run_ff <= ~in_sleep;
      if (in_run) begin
        active_osc_ff <= newsel_ff;
      end
      rc_clk_run_ff <= in_sleep ? wdt_enabled : (wdt_enabled | mon_enabled);
      mon_active_ff <= mon_enabled & ~in_sleep;
      wdt_clear_ff <= (state_ff == pscm_pkg::PS_ENTER) & wdt_enabled;
      cpu_halted_ff <= ~in_run;
      wake_pulse_ff <= halted & wake;
      // peripherals keep full rate in doze; sleep shuts them all
      pce1_ff <= in_sleep ? 16'h0000 : (pscm_pkg::PD1_PRESENT & ~pd1_ff);
      pce2_ff <= in_sleep ? 16'h0000 : (pscm_pkg::PD2_PRESENT & ~pd2_ff);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign cpu_clk_en = cpu_clk_en_ff;
  assign periph_clk_en_one = pce1_ff;
  assign periph_clk_en_two = pce2_ff;
  assign sysclk_run = sysclk_run_ff;
  assign active_osc = active_osc_ff;
  assign rc_clk_run = rc_clk_run_ff;
  assign mon_active = mon_active_ff;
  assign wdt_clear = wdt_clear_ff;
  assign cpu_halted = cpu_halted_ff;
  assign wake_pulse = wake_pulse_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_enter;
    state_ff == pscm_pkg::PS_ENTER;
  endsequence

  sequence s_lowpower(logic slp);
    state_ff == (slp ? pscm_pkg::PS_SLEEP : pscm_pkg::PS_IDLE);
  endsequence

  sequence s_resume;
    in_run ##1 (!cpu_halted_ff && cpu_clk_en_ff);
  endsequence

  a_psave_entry: assert property (
    (in_run & psave_req) |=> s_enter ##1 s_lowpower($past(psave_sleep)))
    else $error("power-save entry sequence wrong");

  a_sleep_clocks_off: assert property (
    in_sleep |=> !sysclk_run & !mon_active & (periph_clk_en_one == 16'h0000) & (periph_clk_en_two == 16'h0000))
    else $error("clocks still live in sleep");

  a_sleep_rc_clock: assert property (
    (in_sleep & wdt_enabled) |=> rc_clk_run)
    else $error("rc clock stopped in sleep with watchdog on");

  a_idle_rc_clock: assert property (
    ((state_ff == pscm_pkg::PS_IDLE) & (wdt_enabled | mon_enabled)) |=> rc_clk_run & sysclk_run)
    else $error("rc or system clock stopped in idle");

  a_entry_wdt_clear: assert property (
    (s_enter and wdt_enabled) |=> wdt_clear ##1 !cpu_clk_en)
    else $error("watchdog not cleared on entry");

  a_wake_resume: assert property (
    (halted & wake & !doze_en_ff & !wr_cdv) |=> s_resume)
    else $error("no resume after wake event");

  a_osc_held: assert property (
    in_sleep |=> $stable(active_osc))
    else $error("oscillator source changed over sleep");

  a_doze_ratio: assert property (
    (in_run & doze_en_ff) |=> cpu_clk_en == $past(dz_cnt_ff == dz_mask(ratio_ff)))
    else $error("cpu enable off its doze ratio");

  a_irq_doze_clear: assert property (
    rtn_hit |=> !doze_en_ff)
    else $error("doze not dropped on interrupt");

  a_disable_delay: assert property (
    (!in_sleep) |=> periph_clk_en_one == (pscm_pkg::PD1_PRESENT & ~$past(pd1_ff)) &&
      periph_clk_en_two == (pscm_pkg::PD2_PRESENT & ~$past(pd2_ff)))
    else $error("module clock enable not one cycle after disable");

  a_unmapped_err: assert property (
    (setup & ~mapped) |=> pready & pslverr & (prdata == 32'h0000_0000))
    else $error("unmapped access not flagged");

endmodule

`default_nettype wire

/* File: pscm_pkg.sv */
package pscm_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_OSC = 8'h00;
  localparam logic [7:0] ADDR_CDV = 8'h04;
  localparam logic [7:0] ADDR_PD1 = 8'h08;
  localparam logic [7:0] ADDR_PD2 = 8'h0C;
  localparam logic [7:0] ADDR_STA = 8'h10;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int OSC_NEWSEL_LSB = 8;
  localparam int CDV_RTN_BIT = 15;
  localparam int CDV_RATIO_LSB = 12;
  localparam int CDV_DOZE_BIT = 11;
  localparam int STA_DOZE_BIT = 2;

  // ----------------------------------------
  // implemented disable bits and variant presence
  // ----------------------------------------
  localparam logic [15:0] PD1_MASK = 16'h38A9;
  localparam logic [15:0] PD2_MASK = 16'hC303;
  localparam logic [15:0] PD1_PRESENT = 16'h38A9;
  localparam logic [15:0] PD2_PRESENT = 16'hC303;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [2:0] NEWSEL_RST = 3'h0;
  localparam logic [2:0] RATIO_RST = 3'h0;
  localparam logic [15:0] PD_RST = 16'h0000;

  // ----------------------------------------
  // timing: one instruction cycle is one pclk
  // ----------------------------------------
  localparam int MOD_DIS_DELAY_CYC = 1;

  // ----------------------------------------
  // power state machine
  // ----------------------------------------
  typedef enum logic [1:0] {
    PS_RUN = 2'b00,
    PS_ENTER = 2'b01,
    PS_SLEEP = 2'b10,
    PS_IDLE = 2'b11
  } pscm_state_t;

endpackage

/* File: pscm_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// core and interrupt source model
// ----------------------------------------
module pscm_core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench commands
  input wire logic go,
  input wire logic go_sleep,
  input wire logic irq_set,
  input wire logic irq_clr,
  // design side
  input wire logic cpu_clk_en,
  input wire logic wake_pulse,
  output logic psave_req,
  output logic psave_sleep,
  output logic irq_pending,
  output logic [15:0] cpu_ticks
);
  // the instruction only issues on a cpu enable, so a dozing core drops a go that meets no enable, never issues early
  // the interrupt stays pending until the wake pulse or a bench clear, which is what a real source does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psave_req <= 1'b0;
      psave_sleep <= 1'b0;
      irq_pending <= 1'b0;
      cpu_ticks <= 16'h0000;
    end else begin
      psave_req <= go & cpu_clk_en;
      psave_sleep <= go ? go_sleep : psave_sleep;
      irq_pending <= irq_set | (irq_pending & ~wake_pulse & ~irq_clr);
      cpu_ticks <= cpu_ticks + 16'(cpu_clk_en);
    end
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, psave_req, psave_sleep, irq_pending, cpu_clk_en;
  logic osc_unlocked = 0, wdt_enabled = 0, mon_enabled = 0, wdt_timeout = 0;
  logic go = 0, go_sleep = 0, irq_set = 0, irq_clr = 0;
  logic [15:0] pe1, pe2, cpu_ticks, t0, msk, pres;
  logic [15:0] pe_exp [2];
  logic sysclk_run, rc_clk_run, mon_active, wdt_clear, cpu_halted, wake_pulse;
  logic [2:0] active_osc;
  logic [32:0] expq [$];
  int seed = 71587, miscompares = 0, total_checks = 0, cyc = 0, k, n;

  // clock at 20 MHz
  always #25 pclk = ~pclk;

  pscm_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psave_req(psave_req), .psave_sleep(psave_sleep), .irq_pending(irq_pending),
    .osc_unlocked(osc_unlocked), .wdt_enabled(wdt_enabled), .mon_enabled(mon_enabled),
    .wdt_timeout(wdt_timeout), .cpu_clk_en(cpu_clk_en), .periph_clk_en_one(pe1),
    .periph_clk_en_two(pe2), .sysclk_run(sysclk_run), .active_osc(active_osc), .rc_clk_run(rc_clk_run),
    .mon_active(mon_active), .wdt_clear(wdt_clear), .cpu_halted(cpu_halted), .wake_pulse(wake_pulse));

  pscm_core_model core_m (.pclk(pclk), .presetn(presetn), .go(go), .go_sleep(go_sleep),
    .irq_set(irq_set), .irq_clr(irq_clr), .cpu_clk_en(cpu_clk_en), .wake_pulse(wake_pulse),
    .psave_req(psave_req), .psave_sleep(psave_sleep), .irq_pending(irq_pending), .cpu_ticks(cpu_ticks));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task close_out;
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // read results are taken only at the edge where the access completes
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check("apb read", {pslverr, prdata}, expq.pop_front());
    end
  end

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 12000) begin
      miscompares++;
      close_out;
    end
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  // starts one edge after any release so no signal is assigned twice in a step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) expq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task core(input logic s, input logic i);
    @(posedge pclk);
    go <= 1'b1;
    go_sleep <= s;
    irq_set <= i;
    @(posedge pclk);
    go <= 1'b0;
    irq_set <= 1'b0;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(negedge pclk);
    check("cpu en", cpu_clk_en, 1);
    check("pe1 rst", pe1, pscm_pkg::PD1_PRESENT);
    check("pe2 rst", pe2, pscm_pkg::PD2_PRESENT);
    apb(0, pscm_pkg::ADDR_PD1, 0, 0);
    apb(0, pscm_pkg::ADDR_PD2, 0, 0);
    apb(0, pscm_pkg::ADDR_CDV, 0, 0);
    apb(0, 8'h20, 0, 33'h1_0000_0000);
    // random disable patterns; enables must lag the write by one cycle
    for (k = 0; k < 2; k++) begin
      r = $random(seed);
      msk = k ? pscm_pkg::PD2_MASK : pscm_pkg::PD1_MASK;
      pres = k ? pscm_pkg::PD2_PRESENT : pscm_pkg::PD1_PRESENT;
      pe_exp[k] = pres & ~(r[15:0] & msk);
      apb(1, k ? pscm_pkg::ADDR_PD2 : pscm_pkg::ADDR_PD1, r, 0);
      @(negedge pclk);
      check("pe hold", k ? pe2 : pe1, pres);
      @(negedge pclk);
      check("pe new", k ? pe2 : pe1, pe_exp[k]);
      apb(0, k ? pscm_pkg::ADDR_PD2 : pscm_pkg::ADDR_PD1, 0, 33'(r[15:0] & msk));
    end
    // oscillator select refused while locked
    apb(1, pscm_pkg::ADDR_OSC, 32'h0000_0500, 0);
    apb(0, pscm_pkg::ADDR_OSC, 0, 0);
    osc_unlocked <= 1'b1;
    apb(1, pscm_pkg::ADDR_OSC, 32'h0000_0500, 0);
    apb(0, pscm_pkg::ADDR_OSC, 0, 33'h0_0000_0500);
    @(negedge pclk);
    check("osc", active_osc, 3'h5);
    // sleep, woken by interrupt then by watchdog time-out
    @(posedge pclk);
    wdt_enabled <= 1'b1;
    mon_enabled <= 1'b1;
    for (k = 0; k < 2; k++) begin
      core(1'b1, 1'b0);
      for (n = 0; n < 20 && wdt_clear !== 1'b1; n++) @(posedge pclk);
      check("wdt clr", wdt_clear, 1);
      repeat (3) @(negedge pclk);
      check("halt", cpu_halted, 1);
      check("sys off", sysclk_run, 0);
      check("mon off", mon_active, 0);
      check("rc on", rc_clk_run, 1);
      check("pe off", {pe2, pe1}, 0);
      @(posedge pclk);
      irq_set <= !k;
      wdt_timeout <= k[0];
      @(posedge pclk);
      irq_set <= 1'b0;
      for (n = 0; n < 20 && wake_pulse !== 1'b1; n++) @(posedge pclk);
      check("wake", wake_pulse, 1);
      wdt_timeout <= 1'b0;
      repeat (2) @(negedge pclk);
      check("cpu back", cpu_clk_en, 1);
      check("run", cpu_halted, 0);
      check("sys on", sysclk_run, 1);
      check("osc kept", active_osc, 3'h5);
    end
    // idle with an interrupt coincident with the instruction
    core(1'b0, 1'b1);
    for (n = 0; n < 20 && wdt_clear !== 1'b1; n++) @(posedge pclk);
    check("idle entry", wdt_clear, 1);
    @(negedge pclk);
    check("idle sys", sysclk_run, 1);
    check("idle rc", rc_clk_run, 1);
    check("idle pe", pe1, pe_exp[0]);
    for (n = 0; n < 20 && wake_pulse !== 1'b1; n++) @(posedge pclk);
    check("idle wake", wake_pulse, 1);
    // every doze ratio; settle past the longest period before counting
    for (n = 0; n < 8; n++) begin
      apb(1, pscm_pkg::ADDR_CDV, 32'h0000_0800 | (n << 12), 0);
      apb(0, pscm_pkg::ADDR_STA, 0, 33'h0_0000_0004);
      repeat (130) @(negedge pclk);
      t0 = cpu_ticks;
      repeat (256) @(negedge pclk);
      check("cpu rate", 33'(cpu_ticks - t0), 33'(256 >> n));
      check("doze pe", pe1, pe_exp[0]);
    end
    // interrupt in doze, without and with return-on-interrupt
    for (k = 0; k < 2; k++) begin
      apb(1, pscm_pkg::ADDR_CDV, 32'({k[0], 15'h2800}), 0);
      @(posedge pclk);
      irq_set <= 1'b1;
      @(posedge pclk);
      irq_set <= 1'b0;
      repeat (4) @(posedge pclk);
      irq_clr <= 1'b1;
      @(posedge pclk);
      irq_clr <= 1'b0;
      apb(0, pscm_pkg::ADDR_CDV, 0, k ? 33'h0_0000_A000 : 33'h0_0000_2800);
    end
    close_out;
  end
endmodule
`default_nettype wire
